// ===== include/acr_defs.svh
// constants for the converter trigger, flag and result controller
// Function
// R1: with auto-trigger enabled, a rising edge of the selected trigger starts a conversion
// R2: done flag sets when a conversion finishes and the result pair is loaded
// R3: interrupt request is high only while flag, irq enable and global enable are set
// R4: taking the matching interrupt vector clears the done flag in hardware
// R5: writing one to the flag position clears it; writing zero leaves it
// R6: prescale codes 0 and 1 divide by 2, codes 2 to 7 by 4 to 128
// R7: right adjust puts result in bits 9..0, left adjust in bits 15..6
// R8: differential channel selections present the result in two's complement
// R9: after a low byte read the result pair holds until the high byte read
// R10: software reads low byte before high; high byte alone suffices for 8-bit left adjust
// R11: trigger source codes 0 to 7 select free running or one of seven event flags
// R12: with auto-trigger disabled the trigger source has no effect on starts
// R13: switching selection from a cleared to a set flag is a rising edge
// R14: switching to free running never creates a trigger event
// R15: software writes zero to the reserved bit of the special function register
// R16: clearing converter enable turns it off and aborts a running conversion
// R17: start bit reads one while converting, zero after; writing zero does nothing
// R18: first conversion after enable takes 25 converter clocks, later ones 13
// R19: a result completing while the pair is locked is discarded
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

`define ACR_OFS_CTRL      8'h00
`define ACR_OFS_RES_LOW   8'h04
`define ACR_OFS_RES_HIGH  8'h08
`define ACR_OFS_SFIO      8'h0C
`define ACR_OFS_CHAN      8'h10

`define ACR_CTRL_ENABLE   7
`define ACR_CTRL_START    6
`define ACR_CTRL_AUTO     5
`define ACR_CTRL_FLAG     4
`define ACR_CTRL_IE       3
`define ACR_SFIO_RSVD     4
`define ACR_CHAN_LEFT     5

`define ACR_RESET_BYTE    8'h00
`define ACR_FIRST_CYCLES  5'd25
`define ACR_NORM_CYCLES   5'd13
`define ACR_DIFF_LO       5'h08
`define ACR_DIFF_HI       5'h1D
`define ACR_SRC_FREE      3'h0

`define ACR_RESP_OKAY     2'h0
`define ACR_RESP_SLVERR   2'h2

`endif

// ===== include/acr_pkg.sv
// types shared by the converter trigger, flag and result controller
package acr_pkg;

   // strobes and selection toward the analog converter core
   typedef struct packed {
      logic       sample_start;
      logic       first_conv;
      logic       conv_tick;
      logic       busy;
      logic [4:0] channel_gain_select;
   } acr_core_req_s;

   // answer from the analog converter core
   typedef struct packed {
      logic [9:0] raw_result;
   } acr_core_rsp_s;

endpackage

// ===== logic/acr_ctrl.sv
// converter trigger, done flag, prescaler and result presentation with AXI4-Lite registers
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "acr_defs.svh"

module acr_ctrl #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire  logic                  aclk,
   input  wire  logic                  aresetn,
   // axi4-lite write address and data
   input  wire  logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire  logic                  s_axi_awvalid,
   output       logic                  s_axi_awready,
   input  wire  logic [31:0]           s_axi_wdata,
   input  wire  logic [3:0]            s_axi_wstrb,
   input  wire  logic                  s_axi_wvalid,
   output       logic                  s_axi_wready,
   // axi4-lite write response
   output       logic [1:0]            s_axi_bresp,
   output       logic                  s_axi_bvalid,
   input  wire  logic                  s_axi_bready,
   // axi4-lite read
   input  wire  logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire  logic                  s_axi_arvalid,
   output       logic                  s_axi_arready,
   output       logic [31:0]           s_axi_rdata,
   output       logic [1:0]            s_axi_rresp,
   output       logic                  s_axi_rvalid,
   input  wire  logic                  s_axi_rready,
   // trigger event flags, index = trigger source code
   input  wire  logic [7:1]            event_flags,
   // processor interrupt side
   input  wire  logic                  global_irq_enable,
   input  wire  logic                  irq_vector_ack,
   output       logic                  conversion_irq,
   // converter core
   output       acr_pkg::acr_core_req_s core_req,
   input  wire  acr_pkg::acr_core_rsp_s core_rsp
);
   import acr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // state

   logic [ADDR_W-1:0] awaddr_q;
   logic              aw_have_q;
   logic [7:0]        wbyte_q;
   logic              wlane_q;
   logic              w_have_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [7:0]        rdata_q;

   logic              enable_q;
   logic              auto_q;
   logic              flag_q;
   logic              ie_q;
   logic [2:0]        prescale_q;
   logic [7:0]        sfio_q;
   logic [7:0]        chan_q;

   logic              busy_q;
   logic              init_done_q;
   logic [4:0]        cyc_q;
   logic [6:0]        pre_q;
   logic              trig_prev_q;
   logic [2:0]        src_prev_q;
   logic [9:0]        res_q;
   logic              lock_q;
   acr_core_req_s     req_q;

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite decode

   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire  = s_axi_wvalid & s_axi_wready;
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire wr_go   = aw_have_q & w_have_q & ~bvalid_q;

   wire wr_ctrl = wr_go & wlane_q & (awaddr_q == ADDR_W'(`ACR_OFS_CTRL));
   wire wr_sfio = wr_go & wlane_q & (awaddr_q == ADDR_W'(`ACR_OFS_SFIO));
   wire wr_chan = wr_go & wlane_q & (awaddr_q == ADDR_W'(`ACR_OFS_CHAN));
   wire wr_map  = (awaddr_q == ADDR_W'(`ACR_OFS_CTRL)) |
                  (awaddr_q == ADDR_W'(`ACR_OFS_RES_LOW)) |
                  (awaddr_q == ADDR_W'(`ACR_OFS_RES_HIGH)) |
                  (awaddr_q == ADDR_W'(`ACR_OFS_SFIO)) |
                  (awaddr_q == ADDR_W'(`ACR_OFS_CHAN));

   wire rd_ctrl = s_axi_araddr == ADDR_W'(`ACR_OFS_CTRL);
   wire rd_low  = s_axi_araddr == ADDR_W'(`ACR_OFS_RES_LOW);
   wire rd_high = s_axi_araddr == ADDR_W'(`ACR_OFS_RES_HIGH);
   wire rd_sfio = s_axi_araddr == ADDR_W'(`ACR_OFS_SFIO);
   wire rd_chan = s_axi_araddr == ADDR_W'(`ACR_OFS_CHAN);
   wire rd_map  = rd_ctrl | rd_low | rd_high | rd_sfio | rd_chan;

   assign s_axi_awready = ~aw_have_q;
   assign s_axi_wready  = ~w_have_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = {24'h000000, rdata_q};

   ////////////////////////////////////////////////////////////////////////////////
   // result presentation

   wire [15:0] pres_word = chan_q[`ACR_CHAN_LEFT] ? {res_q, 6'h00}  // R7
                                                  : {6'h00, res_q};  // R7
   wire [7:0]  ctrl_rd   = {enable_q, busy_q, auto_q, flag_q, ie_q, prescale_q};  // R17
   wire [7:0]  rd_mux    = rd_ctrl ? ctrl_rd :
                           rd_low  ? pres_word[7:0] :
                           rd_high ? pres_word[15:8] :
                           rd_sfio ? sfio_q :
                           rd_chan ? chan_q : 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // control decode

   wire       wr_en_new  = wbyte_q[`ACR_CTRL_ENABLE];
   wire       en_next    = wr_ctrl ? wr_en_new : enable_q;
   wire       abort      = wr_ctrl & ~wr_en_new;  // R16
   wire [2:0] src        = sfio_q[7:5];

   // free running follows the done flag itself, so a conversion starts each time the flag goes from clear to set
   wire [7:0] trig_vec   = {event_flags, flag_q};
   wire       trig_sig   = trig_vec[src];  // R11
   // a change to free running would otherwise look like an edge on a set flag
   wire       to_free    = (src == `ACR_SRC_FREE) & (src_prev_q != `ACR_SRC_FREE);  // R14
   wire       trig_edge  = trig_sig & ~trig_prev_q & ~to_free;  // R13
   wire       auto_start = enable_q & auto_q & trig_edge;  // R1 R12
   wire       sw_start   = wr_ctrl & wr_en_new & wbyte_q[`ACR_CTRL_START];  // R17
   wire       start      = (sw_start | auto_start) & en_next & ~busy_q;

   // prescaler: codes below 2 divide by 2
   wire [2:0] shift      = (prescale_q < 3'h2) ? 3'h1 : prescale_q;  // R6
   wire [6:0] pre_top    = 7'((8'h01 << shift) - 8'h01);  // R6
   wire       tick       = enable_q & (pre_q == pre_top);

   wire [4:0] conv_len   = init_done_q ? `ACR_NORM_CYCLES : `ACR_FIRST_CYCLES;  // R18
   wire       conv_end   = busy_q & tick & (cyc_q == 5'(conv_len - 5'd1));  // R18
   // a result landing while the pair is locked is lost, flag included
   wire       load_res   = conv_end & ~lock_q;  // R19

   wire [4:0] mux_sel    = chan_q[4:0];
   wire       diff_sel   = (mux_sel >= `ACR_DIFF_LO) & (mux_sel <= `ACR_DIFF_HI);
   wire [9:0] raw        = core_rsp.raw_result;
   // the core hands offset binary; flipping the top bit gives two's complement
   wire [9:0] res_new    = diff_sel ? {~raw[9], raw[8:0]} : raw;  // R8

   wire       flag_clr   = (wr_ctrl & wbyte_q[`ACR_CTRL_FLAG]) | irq_vector_ack;  // R4 R5
   // a completion in the clearing cycle keeps the flag set
   wire       flag_d     = load_res | (flag_q & ~flag_clr);  // R2

   assign conversion_irq = flag_q & ie_q & global_irq_enable;  // R3
   assign core_req       = req_q;

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite channel registers

   // an address is only taken while none is held, so take and release never meet
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q  <= '0;
         aw_have_q <= 1'b0;
      end else if (aw_fire) begin
         awaddr_q  <= s_axi_awaddr;
         aw_have_q <= 1'b1;
      end else if (wr_go) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wbyte_q  <= `ACR_RESET_BYTE;
         wlane_q  <= 1'b0;
         w_have_q <= 1'b0;
      end else if (w_fire) begin
         wbyte_q  <= s_axi_wdata[7:0];
         wlane_q  <= s_axi_wstrb[0];
         w_have_q <= 1'b1;
      end else if (wr_go) begin
         w_have_q <= 1'b0;
      end
   end

   // the next write waits for bvalid to drop, so one response stands at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `ACR_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_map ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // arready is low while rvalid stands, so the data cannot move under the master
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
      end else if (ar_fire) begin
         rvalid_q <= 1'b1;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rresp_q <= `ACR_RESP_OKAY;
         rdata_q <= `ACR_RESET_BYTE;
      end else if (ar_fire) begin
         rresp_q <= rd_map ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
         rdata_q <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // software registers

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_q   <= 1'b0;
         auto_q     <= 1'b0;
         ie_q       <= 1'b0;
         prescale_q <= 3'h0;
      end else if (wr_ctrl) begin
         enable_q   <= wr_en_new;  // R16
         auto_q     <= wbyte_q[`ACR_CTRL_AUTO];
         ie_q       <= wbyte_q[`ACR_CTRL_IE];
         prescale_q <= wbyte_q[2:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;  // R2 R4 R5
      end
   end

   // the reserved bit is read-only zero whatever software writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sfio_q <= `ACR_RESET_BYTE;
      end else if (wr_sfio) begin
         sfio_q <= wbyte_q & ~(8'h01 << `ACR_SFIO_RSVD);  // R15
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_q <= `ACR_RESET_BYTE;
      end else if (wr_chan) begin
         chan_q <= wbyte_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // trigger edge detection

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_prev_q <= 1'b0;
      end else begin
         trig_prev_q <= trig_sig;  // R13
      end
   end

   // remembered so that a switch to free running can be told from a flag edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_prev_q <= `ACR_SRC_FREE;
      end else begin
         src_prev_q <= src;  // R14
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // prescaler and conversion sequencing

   // the divider runs from enable, so the first converter clock may come early
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_q <= 7'h00;
      end else if (!enable_q || tick) begin
         pre_q <= 7'h00;
      end else begin
         pre_q <= 7'(pre_q + 7'h01);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_q <= 1'b0;
         cyc_q  <= 5'h00;
      end else if (abort) begin
         busy_q <= 1'b0;  // R16
         cyc_q  <= 5'h00;
      end else if (start) begin
         busy_q <= 1'b1;
         cyc_q  <= 5'h00;
      end else if (conv_end) begin
         busy_q <= 1'b0;  // R17
         cyc_q  <= 5'h00;
      end else if (busy_q && tick) begin
         cyc_q <= 5'(cyc_q + 5'h01);
      end
   end

   // start needs an idle converter and the end a busy one, so they never meet
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         init_done_q <= 1'b0;
      end else if (abort) begin
         init_done_q <= 1'b0;  // R18
      end else if (conv_end) begin
         init_done_q <= 1'b1;  // R18
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // result register and read lock

   wire rd_low_go  = ar_fire & rd_low;
   wire rd_high_go = ar_fire & rd_high;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res_q <= 10'h000;
      end else if (load_res) begin
         res_q <= res_new;  // R2 R9
      end
   end

   // a high byte read releases the pair, so it wins over a low byte read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_q <= 1'b0;
      end else if (rd_high_go) begin
         lock_q <= 1'b0;  // R9 R10
      end else if (rd_low_go) begin
         lock_q <= 1'b1;  // R9
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // converter core strobes

   // every strobe reaches the core one cycle late, which the core must allow for
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_q <= '0;
      end else begin
         req_q.sample_start        <= start;
         req_q.first_conv          <= start ? ~init_done_q : req_q.first_conv;
         req_q.conv_tick           <= tick & busy_q;
         req_q.busy                <= busy_q;
         req_q.channel_gain_select <= chan_q[4:0];
      end
   end

endmodule

// ===== bench/acr_core_mdl.sv
// behavioural converter core that holds one sample per conversion
`timescale 1ns/10ps
module acr_core_mdl (
   // clock
   input  wire logic                   aclk,
   // controller side
   input  wire acr_pkg::acr_core_req_s core_req,
   input  wire logic [9:0]             next_raw,
   output      acr_pkg::acr_core_rsp_s core_rsp
);
   import acr_pkg::*;
   logic [9:0] held_q;
   always_ff @(posedge aclk) begin
      if (core_req.sample_start) begin
         held_q <= next_raw;
      end
   end
   // outside a conversion the sample is gone, so show a wrong value there
   assign core_rsp.raw_result = core_req.busy ? held_q : ~held_q;
endmodule

// ===== bench/acr_ctrl_chk.sv
// port assertions for the converter controller
`timescale 1ns/10ps
module acr_ctrl_chk (
   // clock and reset
   input wire logic                   aclk,
   input wire logic                   aresetn,
   // register bus
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   // interrupt and core
   input wire logic                   global_irq_enable,
   input wire logic                   irq_vector_ack,
   input wire logic                   conversion_irq,
   input wire acr_pkg::acr_core_req_s core_req
);
   import acr_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_take_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take_s;
      s_axi_arvalid && s_axi_arready;
   endsequence
   wr_resp_a: assert property (wr_take_s |-> ##2 s_axi_bvalid)
      else $error("write response late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
                              s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
      else $error("read answer not next cycle");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
                               s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   ar_block_a: assert property (s_axi_arready != s_axi_rvalid)
      else $error("read address ready wrong");
   rd_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   irq_gate_a: assert property (!global_irq_enable |-> !conversion_irq)
      else $error("interrupt without global enable");
   irq_ack_a: assert property (irq_vector_ack && !core_req.busy |=> !conversion_irq)
      else $error("vector did not clear flag");
   start_pulse_a: assert property (core_req.sample_start |=>
                                   !core_req.sample_start && core_req.busy)
      else $error("start pulse wrong");
   busy_tick_a: assert property ($rose(core_req.busy) |-> ##[0:300] core_req.conv_tick)
      else $error("no converter clock");
   reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active in reset");
endmodule
bind acr_ctrl acr_ctrl_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .global_irq_enable, .irq_vector_ack,
   .conversion_irq, .core_req);

// ===== bench/acr_ctrl_tb.sv
// self-checking bench for the converter controller
`timescale 1ns/10ps
module acr_ctrl_tb;
   import acr_pkg::*;
   logic          aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic          s_axi_rvalid, s_axi_rready, global_irq_enable, irq_vector_ack, conversion_irq;
   logic [7:0]    s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata;
   logic [3:0]    s_axi_wstrb;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic [7:1]    event_flags;
   logic [9:0]    r, v;
   acr_core_req_s core_req;
   acr_core_rsp_s core_rsp;
   logic [33:0]   rq[$];
   logic [1:0]    bq[$];
   int            mismatches, num_checks, n, d;
   acr_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .event_flags, .global_irq_enable, .irq_vector_ack, .conversion_irq,
      .core_req, .core_rsp);
   acr_core_mdl u_core (.aclk, .core_req, .next_raw(r), .core_rsp);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input logic [33:0] a, input logic [33:0] e);
      num_checks++;
      if (a !== e) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, a, e);
      end
   endtask
   task automatic ok(input logic c);
      cmp({33'h0, c}, 34'h1);
   endtask
   // kinds: 0 write ready, 1 bvalid, 2 rvalid, 3 interrupt, 4 arready
   task automatic wait_for(input int k);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > 5000) begin
            mismatches++;
            test_done();
         end
      end while (!(k == 0 ? s_axi_awready && s_axi_wready : k == 1 ? s_axi_bvalid :
                   k == 2 ? s_axi_rvalid : k == 3 ? conversion_irq : s_axi_arready));
   endtask
   // ready may be raised late, so the slave must hold its answer meanwhile
   task automatic wr(input logic [7:0] a, input logic [7:0] dt, input logic [1:0] e = 2'h0);
      bq.push_back(e);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'($urandom), dt};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'($urandom);
      wait_for(0);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      wait_for(1);
      if (!s_axi_bready) begin
         s_axi_bready <= 1'b1;
         @(posedge aclk);
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] rs = 2'h0);
      rq.push_back({rs, 24'h0, e});
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'($urandom);
      wait_for(4);
      s_axi_arvalid <= 1'b0;
      wait_for(2);
      if (!s_axi_rready) begin
         s_axi_rready <= 1'b1;
         @(posedge aclk);
      end
      s_axi_rready <= 1'b0;
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
         cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
         cmp({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, event_flags, irq_vector_ack} = '0;
      s_axi_wstrb = 4'hF;
      global_irq_enable = 1'b1;
      r = 10'h000;
      void'($urandom(32'h5F6CFFB2));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h0C, 8'h00);
      rd(8'h14, 8'h00, 2'h2);
      wr(8'h14, 8'hFF, 2'h2);
      r <= 10'($urandom);
      wr(8'h00, 8'hC8);
      rd(8'h00, 8'hC8);
      wait_for(3);
      ok(n > 38 && n < 54);
      rd(8'h04, r[7:0]);
      rd(8'h08, {6'h00, r[9:8]});
      rd(8'h00, 8'h98);
      wr(8'h00, 8'h88);
      ok(conversion_irq === 1'b1);
      global_irq_enable <= 1'b0;
      repeat (2) @(posedge aclk);
      ok(conversion_irq === 1'b0);
      global_irq_enable <= 1'b1;
      irq_vector_ack <= 1'b1;
      @(posedge aclk);
      irq_vector_ack <= 1'b0;
      repeat (2) @(posedge aclk);
      ok(conversion_irq === 1'b0);
      for (int p = 0; p < 8; p++) begin
         d = p < 2 ? 2 : 1 << p;
         wr(8'h00, 8'hD8 | 8'(p));
         ok(conversion_irq === 1'b0);
         wait_for(3);
         ok(n > 11 * d - 8 && n < 14 * d + 4);
      end
      r <= 10'($urandom);
      wr(8'h10, 8'h28);
      wr(8'h00, 8'hD8);
      wait_for(3);
      v = r ^ 10'h200;
      rd(8'h04, {v[1:0], 6'h00});
      r <= ~r;
      wr(8'h00, 8'hD8);
      repeat (60) @(posedge aclk);
      rd(8'h00, 8'h88);
      rd(8'h08, v[9:2]);
      wr(8'h10, 8'h00);
      for (int c = 1; c < 8; c++) begin
         wr(8'h0C, 8'(c << 5));
         wr(8'h00, 8'hB8);
         event_flags[c] <= 1'b1;
         wait_for(3);
         ok(n < 40);
         event_flags <= '0;
      end
      wr(8'h00, 8'h98);
      event_flags[7] <= 1'b1;
      repeat (60) @(posedge aclk);
      ok(conversion_irq === 1'b0);
      event_flags <= 7'h02;
      wr(8'h00, 8'hA8);
      wr(8'h0C, 8'h40);
      wait_for(3);
      ok(n < 40);
      // selected flag low first, so the switch to the set done flag would be an edge
      event_flags <= '0;
      wr(8'h0C, 8'h00);
      rd(8'h00, 8'hB8);
      wr(8'h0C, 8'h0A);
      rd(8'h0C, 8'h0A);
      wr(8'h00, 8'hD8);
      repeat (4) @(posedge aclk);
      wr(8'h00, 8'h08);
      rd(8'h00, 8'h08);
      repeat (80) @(posedge aclk);
      ok(conversion_irq === 1'b0);
      test_done();
   end
endmodule
